// *** rtl/lecr_pkg.sv ***
// Package with offsets, field positions and reset values of the block.
package lecr_pkg;
	// Configuration space offsets of the registers.
	localparam logic [7:0] CFG_BAR_OFS = 8'h10;
	localparam logic [7:0] CFG_LEC_OFS = 8'hF4;
	localparam logic [7:0] CFG_SUBSYS_OFS = 8'hF8;
	// Memory window: 2 KB, so eleven offset bits.
	localparam int WIN_BITS = 11;
	localparam logic [31:0] BAR_MASK = 32'hFFFF_F800;
	localparam logic [31:0] BAR_RESET = 32'h0000_0000;
	// Set/clear register pairs inside the memory window.
	localparam logic [10:0] MEM_EVT_SET = 11'h080;
	localparam logic [10:0] MEM_EVT_CLR = 11'h084;
	localparam logic [10:0] MEM_MSK_SET = 11'h088;
	localparam logic [10:0] MEM_MSK_CLR = 11'h08C;
	// Link enhancement control field positions.
	localparam int LEC_TRANSPORT_BIT = 10;
	localparam int LEC_VIDEO_BIT = 8;
	localparam int LEC_PRIO_BIT = 7;
	localparam int LEC_RSVD2_BIT = 2;
	localparam int LEC_ACCEL_BIT = 1;
	// Writable bits 10, 8, 7, 2 and 1; every other bit reads zero.
	localparam logic [31:0] LEC_WMASK = 32'h0000_0586;
	localparam logic [31:0] LEC_RESET = 32'h0000_0000;
	// Subsystem alias: device id high half, vendor id low half.
	localparam logic [31:0] SUBSYS_RESET = 32'h0000_0000;
	localparam int SUBDEV_LSB = 16;
	localparam logic [31:0] SC_RESET = 32'h0000_0000;
	// Stream format codes that receive the timestamp enhancement.
	localparam logic [5:0] FORMAT_TRANSPORT = 6'h20;
	localparam logic [5:0] FORMAT_VIDEO = 6'h00;
	// Source of the word returned by a read.
	typedef enum logic [1:0] {
		LECR_SRC_NONE = 2'b00,
		LECR_SRC_CFG = 2'b01,
		LECR_SRC_MEM = 2'b10
	} lecr_src_t;
endpackage

// *** rtl/lecr_sc_if.sv ***
// Interface joining the register decoder to one set/clear register.
`timescale 1ns/1ps
interface lecr_sc_if;
	logic set_wr; // Write strobe at the set address.
	logic clr_wr; // Write strobe at the clear address.
	logic [31:0] wdata; // Written word, one bit per flag.
	logic [31:0] hw_set; // Hardware events that set flags.
	logic [31:0] value; // Current contents.
	modport owner (output set_wr, output clr_wr, output wdata,
		output hw_set, input value);
	modport store (input set_wr, input clr_wr, input wdata,
		input hw_set, output value);
endinterface // lecr_sc_if

// *** rtl/lecr_setclr.sv ***
// Generic set/clear register with hardware set inputs.
`timescale 1ns/1ps
module lecr_setclr (
	input wire logic core_clk,
	input wire logic srst,
	lecr_sc_if.store sc
);
	// Masks formed from the two strobes.
	wire [31:0] set_bits = sc.set_wr ? sc.wdata : 32'h0000_0000;
	wire [31:0] clr_bits = sc.clr_wr ? sc.wdata : 32'h0000_0000;
	// Hardware set is ORed last so an event never loses to a clear.
	wire [31:0] next_value = (sc.value & ~clr_bits) | set_bits | sc.hw_set;

	// Holds the flags; reset clears every bit.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			sc.value <= lecr_pkg::SC_RESET;
		else
			sc.value <= next_value; // RQ13 RQ14
	end

	chk_set_ones: assert property (@(posedge core_clk) disable iff (srst) // RQ13
		sc.set_wr |=> ((sc.value & $past(sc.wdata)) == $past(sc.wdata)))
		else $error("set write did not set its one bits");
	chk_clr_ones: assert property (@(posedge core_clk) disable iff (srst) // RQ14
		sc.clr_wr |=> ((sc.value & $past(sc.wdata) & ~$past(sc.hw_set))
		== 32'h0000_0000))
		else $error("clear write did not clear its one bits");
	chk_zero_keeps: assert property (@(posedge core_clk) disable iff (srst) // RQ13
		(sc.set_wr || sc.clr_wr) |=> ((sc.value & ~$past(sc.wdata)) ==
		(($past(sc.value) | $past(sc.hw_set)) & ~$past(sc.wdata))))
		else $error("zero bits of a write changed the register");
endmodule // lecr_setclr

// *** rtl/lecr_stamp.sv ***
// Picks transmitted CIP streams that get the timestamp enhancement.
`timescale 1ns/1ps
module lecr_stamp (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic tx_valid,
	input wire logic [5:0] stream_format_code,
	input wire logic transport_en,
	input wire logic video_en,
	output logic boost
);
	// Each format is enhanced only while its own enable is set.
	wire hit_transport = transport_en &&
		(stream_format_code == lecr_pkg::FORMAT_TRANSPORT);
	wire hit_video = video_en &&
		(stream_format_code == lecr_pkg::FORMAT_VIDEO);
	wire next_boost = tx_valid && (hit_transport || hit_video);

	// Registered so that the top output comes from a flip-flop.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			boost <= 1'b0;
		else
			boost <= next_boost; // RQ1 RQ3
	end

	chk_stamp_mpeg: assert property (@(posedge core_clk) disable iff (srst) // RQ1
		(tx_valid && transport_en &&
		stream_format_code == lecr_pkg::FORMAT_TRANSPORT) |=> boost)
		else $error("format 20h stream was not enhanced");
	chk_stamp_off: assert property (@(posedge core_clk) disable iff (srst) // RQ3
		(tx_valid && !video_en && !transport_en) |=> !boost)
		else $error("stream enhanced with both enables clear");
endmodule // lecr_stamp

// *** rtl/lecr_regs.sv ***
// Link enhancement, subsystem alias and set/clear register logic.
// How it works
// [RQ1] Bit 10 enhances format 20h streams.
// [RQ2] Bit 9 always reads zero.
// [RQ3] Bit 8 enhances format 00h streams.
// [RQ4] Bit 7 turns on priority arbitration.
// [RQ5] Bits 6 to 3 always read zero.
// [RQ6] Software keeps bit 2 zero; resets zero.
// [RQ7] Bit 1 tells PHY about acceleration support.
// [RQ8] Bit 0 always reads zero.
// [RQ9] Alias write updates subsystem ID registers.
// [RQ10] Alias reads back last write, resets zero.
// [RQ11] Device id high half, vendor id low.
// [RQ12] Link registers decode in 2 KB window.
// [RQ13] Set address sets bits written as one.
// [RQ14] Clear address clears bits written as one.
// [RQ15] Either address reads current contents.
// [RQ16] Event clear address reads masked contents.
// [RQ17] Writes to read-only bits are ignored.
`timescale 1ns/1ps
module lecr_regs (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [31:0] evt_in,
	input wire logic tx_valid,
	input wire logic [5:0] stream_format_code,
	output logic [31:0] rd_data,
	output logic rd_valid,
	output logic transport_stamp_boost_en,
	output logic video_stamp_boost_en,
	output logic priority_arb_en,
	output logic phy_accel_notify,
	output logic [15:0] subsystem_device_alias,
	output logic [15:0] subsystem_vendor_alias,
	output logic subsys_id_load,
	output logic stamp_boost
);
	// Stored link enhancement word; only writable bits are ever set.
	logic [31:0] lec;
	// Subsystem alias word as last written.
	logic [31:0] subsys;
	// Base address of the link register window.
	logic [31:0] bar;
	// Source chosen for the read answer.
	lecr_pkg::lecr_src_t src;

	// Interrupt event and mask set/clear pairs.
	lecr_sc_if evt_sc ();
	lecr_sc_if msk_sc ();

	// Configuration space decode.
	wire cfg_hit_lec = (cfg_addr == lecr_pkg::CFG_LEC_OFS);
	wire cfg_hit_sub = (cfg_addr == lecr_pkg::CFG_SUBSYS_OFS);
	wire cfg_hit_bar = (cfg_addr == lecr_pkg::CFG_BAR_OFS);
	wire lec_we = cfg_wr && cfg_hit_lec;
	wire sub_we = cfg_wr && cfg_hit_sub;
	wire bar_we = cfg_wr && cfg_hit_bar;

	// The window holds only the upper address bits of the base; the
	// low eleven bits select a register inside the 2 KB window.
	wire mem_hit = ((mem_addr & lecr_pkg::BAR_MASK) == bar); // RQ12
	wire [10:0] mem_ofs = mem_addr[10:0];
	wire mem_we = mem_wr && mem_hit;

	// Write strobes for the two set/clear pairs.
	wire evt_set_we = mem_we && (mem_ofs == lecr_pkg::MEM_EVT_SET);
	wire evt_clr_we = mem_we && (mem_ofs == lecr_pkg::MEM_EVT_CLR);
	wire msk_set_we = mem_we && (mem_ofs == lecr_pkg::MEM_MSK_SET);
	wire msk_clr_we = mem_we && (mem_ofs == lecr_pkg::MEM_MSK_CLR);

	// Only the writable bits of a write reach the stored word, so the
	// reserved read-only bits can never become one.
	wire [31:0] next_lec = cfg_wdata & lecr_pkg::LEC_WMASK; // RQ17

	// Configuration read word.
	wire [31:0] cfg_rword =
		cfg_hit_lec ? (lec & lecr_pkg::LEC_WMASK) : // RQ2 RQ5 RQ8
		cfg_hit_sub ? subsys : // RQ10
		cfg_hit_bar ? bar :
		32'h0000_0000;

	// The event pair reads masked at its clear address; all other pair
	// addresses read raw contents. Unmapped window words read zero.
	wire [31:0] evt_masked = evt_sc.value & msk_sc.value;
	wire [31:0] mem_rword =
		!mem_hit ? 32'h0000_0000 :
		(mem_ofs == lecr_pkg::MEM_EVT_SET) ? evt_sc.value : // RQ15
		(mem_ofs == lecr_pkg::MEM_EVT_CLR) ? evt_masked : // RQ16
		(mem_ofs == lecr_pkg::MEM_MSK_SET) ? msk_sc.value : // RQ15
		(mem_ofs == lecr_pkg::MEM_MSK_CLR) ? msk_sc.value : // RQ15
		32'h0000_0000;

	// A configuration read wins if both reads arrive together; the
	// memory read is then dropped and the requester must retry.
	wire lecr_pkg::lecr_src_t next_src =
		cfg_rd ? lecr_pkg::LECR_SRC_CFG :
		mem_rd ? lecr_pkg::LECR_SRC_MEM :
		lecr_pkg::LECR_SRC_NONE;

	// Drive the set/clear pairs; events come from core logic on this
	// clock, so they need no synchroniser.
	assign evt_sc.set_wr = evt_set_we;
	assign evt_sc.clr_wr = evt_clr_we;
	assign evt_sc.wdata = mem_wdata;
	assign evt_sc.hw_set = evt_in;
	assign msk_sc.set_wr = msk_set_we;
	assign msk_sc.clr_wr = msk_clr_we;
	assign msk_sc.wdata = mem_wdata;
	assign msk_sc.hw_set = 32'h0000_0000;

	// Event flags: hardware set beats a software clear.
	lecr_setclr u_evt (
		.core_clk(core_clk),
		.srst(srst),
		.sc(evt_sc)
	);

	// Mask flags: software only.
	lecr_setclr u_msk (
		.core_clk(core_clk),
		.srst(srst),
		.sc(msk_sc)
	);

	// Stream selector for the timestamp enhancement.
	lecr_stamp u_stamp (
		.core_clk(core_clk),
		.srst(srst),
		.tx_valid(tx_valid),
		.stream_format_code(stream_format_code),
		.transport_en(lec[lecr_pkg::LEC_TRANSPORT_BIT]),
		.video_en(lec[lecr_pkg::LEC_VIDEO_BIT]),
		.boost(stamp_boost)
	);

	// Link enhancement word; all fields reset to zero, bit 2 included.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			lec <= lecr_pkg::LEC_RESET; // RQ6
		else if (lec_we)
			lec <= next_lec; // RQ17
	end

	// Subsystem alias; both halves are writable.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			subsys <= lecr_pkg::SUBSYS_RESET; // RQ10
		else if (sub_we)
			subsys <= cfg_wdata; // RQ10 RQ11
	end

	// Window base; the low bits are hard zero to keep 2 KB alignment.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			bar <= lecr_pkg::BAR_RESET;
		else if (bar_we)
			bar <= cfg_wdata & lecr_pkg::BAR_MASK; // RQ12
	end

	// Enable outputs copy the stored fields one cycle after a write.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			transport_stamp_boost_en <= 1'b0;
			video_stamp_boost_en <= 1'b0;
			priority_arb_en <= 1'b0;
			phy_accel_notify <= 1'b0;
		end
		else
		begin
			transport_stamp_boost_en <= lec[lecr_pkg::LEC_TRANSPORT_BIT]; // RQ1
			video_stamp_boost_en <= lec[lecr_pkg::LEC_VIDEO_BIT]; // RQ3
			priority_arb_en <= lec[lecr_pkg::LEC_PRIO_BIT]; // RQ4
			phy_accel_notify <= lec[lecr_pkg::LEC_ACCEL_BIT]; // RQ7
		end
	end

	// The subsystem ID registers take the written value with a load
	// pulse, so they follow the alias without a second write.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			subsystem_device_alias <= 16'h0000;
			subsystem_vendor_alias <= 16'h0000;
			subsys_id_load <= 1'b0;
		end
		else
		begin
			subsys_id_load <= sub_we; // RQ9
			if (sub_we)
			begin
				subsystem_device_alias <= cfg_wdata[31:16]; // RQ9 RQ11
				subsystem_vendor_alias <= cfg_wdata[15:0]; // RQ9 RQ11
			end
		end
	end

	// Read answer: one cycle after the request, valid for one cycle.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			src <= lecr_pkg::LECR_SRC_NONE;
		else
			src <= next_src;
	end

	// Data is captured with the request so later writes cannot alter it.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rd_data <= 32'h0000_0000;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= cfg_rd || mem_rd;
			case (next_src)
				lecr_pkg::LECR_SRC_CFG: rd_data <= cfg_rword;
				lecr_pkg::LECR_SRC_MEM: rd_data <= mem_rword;
				lecr_pkg::LECR_SRC_NONE: rd_data <= 32'h0000_0000;
				default: rd_data <= 32'h0000_0000;
			endcase
		end
	end

	// Reserved link enhancement bits must read back as zero.
	chk_lec_rsvd_zero: assert property ( // RQ2 RQ5 RQ8
		@(posedge core_clk) disable iff (srst)
		(cfg_rd && cfg_hit_lec) |=>
		(rd_data[9] == 1'b0 && rd_data[6:3] == 4'h0 && rd_data[0] == 1'b0
		&& rd_data[31:11] == 21'h0))
		else $error("reserved enhancement bit read as one");
	// A write read back in the next cycle shows only its writable bits.
	chk_lec_wback: assert property ( // RQ17
		@(posedge core_clk) disable iff (srst)
		(lec_we && !cfg_rd) ##1 (cfg_rd && cfg_hit_lec) |=>
		(rd_data == ($past(cfg_wdata, 2) & lecr_pkg::LEC_WMASK)))
		else $error("enhancement read-back differs from masked write");
	// The outputs lag the stored word by one edge, so look two edges on.
	chk_lec_enables: assert property ( // RQ4 RQ7
		@(posedge core_clk) disable iff (srst)
		lec_we |-> ##2 (priority_arb_en == $past(cfg_wdata[7], 2)
		&& phy_accel_notify == $past(cfg_wdata[1], 2)))
		else $error("priority or acceleration enable did not follow write");
	// Both timestamp enables follow a write the same way.
	chk_lec_mpeg_en: assert property ( // RQ1 RQ3
		@(posedge core_clk) disable iff (srst)
		lec_we |-> ##2 (transport_stamp_boost_en == $past(cfg_wdata[10], 2)
		&& video_stamp_boost_en == $past(cfg_wdata[8], 2)))
		else $error("timestamp enable did not follow write");
	// An alias write reaches both ID halves with a load pulse.
	chk_sub_load: assert property ( // RQ9
		@(posedge core_clk) disable iff (srst)
		sub_we |=> (subsys_id_load &&
		{subsystem_device_alias, subsystem_vendor_alias} == $past(cfg_wdata)))
		else $error("subsystem ID registers not updated by alias write");
	// Without an alias write the ID registers must not move.
	chk_sub_hold: assert property ( // RQ9 RQ11
		@(posedge core_clk) disable iff (srst)
		!sub_we |=> ($stable(subsystem_device_alias)
		&& $stable(subsystem_vendor_alias) && !subsys_id_load))
		else $error("subsystem ID registers changed without a write");
	// The alias reads back the word written just before.
	chk_sub_rback: assert property ( // RQ10 RQ11
		@(posedge core_clk) disable iff (srst)
		(sub_we && !cfg_rd) ##1 (cfg_rd && cfg_hit_sub && !cfg_wr) |=>
		(rd_data == $past(cfg_wdata, 2)))
		else $error("alias did not read back last written value");
	// The event clear address hides events whose mask bit is clear.
	chk_evt_masked: assert property ( // RQ16
		@(posedge core_clk) disable iff (srst)
		(mem_rd && !cfg_rd && mem_hit && mem_ofs == lecr_pkg::MEM_EVT_CLR)
		|=> (rd_data == ($past(evt_sc.value) & $past(msk_sc.value))))
		else $error("event clear address did not read masked value");
	// The event set address shows the raw flags.
	chk_evt_raw: assert property ( // RQ15
		@(posedge core_clk) disable iff (srst)
		(mem_rd && !cfg_rd && mem_hit && mem_ofs == lecr_pkg::MEM_EVT_SET)
		|=> (rd_data == $past(evt_sc.value)))
		else $error("event set address did not read raw value");
	// Both mask addresses show the raw mask.
	chk_msk_raw: assert property ( // RQ15
		@(posedge core_clk) disable iff (srst)
		(mem_rd && !cfg_rd && mem_hit && (mem_ofs == lecr_pkg::MEM_MSK_SET
		|| mem_ofs == lecr_pkg::MEM_MSK_CLR))
		|=> (rd_data == $past(msk_sc.value)))
		else $error("mask address did not read raw value");
	// A read outside the window is answered, but with zero.
	chk_win_miss: assert property ( // RQ12
		@(posedge core_clk) disable iff (srst)
		(mem_rd && !cfg_rd && !mem_hit) |=> (rd_valid && rd_data == 32'h0))
		else $error("access outside the window returned data");
	// The window base keeps only its aligned upper bits.
	chk_bar_wback: assert property ( // RQ12
		@(posedge core_clk) disable iff (srst)
		(bar_we && !cfg_rd) ##1 (cfg_rd && cfg_hit_bar && !cfg_wr) |=>
		(rd_data == ($past(cfg_wdata, 2) & lecr_pkg::BAR_MASK)))
		else $error("window base read-back is not aligned to 2 KB");
	// Every read is answered exactly one edge later.
	chk_rd_answer: assert property ( // RQ15
		@(posedge core_clk) disable iff (srst)
		(cfg_rd || mem_rd) |=> (rd_valid && src != lecr_pkg::LECR_SRC_NONE))
		else $error("read request got no answer");
	// A configuration read always takes the answer slot.
	chk_rd_cfg_wins: assert property ( // RQ15
		@(posedge core_clk) disable iff (srst)
		cfg_rd |=> (src == lecr_pkg::LECR_SRC_CFG))
		else $error("configuration read lost the answer slot");
endmodule // lecr_regs

// *** sim/testbench.sv ***
// Self-checking bench for the link enhancement and alias register block.
`timescale 1ns/1ps
module testbench;
	logic core_clk; // Core clock, 50 MHz.
	logic srst; // Synchronous reset, active high.
	logic cfg_wr, cfg_rd, mem_wr, mem_rd, tx_valid; // Request strobes.
	logic [7:0] cfg_addr; // Configuration offset.
	logic [31:0] cfg_wdata, mem_addr, mem_wdata, evt_in; // Bus values.
	logic [5:0] stream_format_code; // Format of the presented packet.
	logic [31:0] rd_data;
	logic rd_valid, transport_stamp_boost_en, video_stamp_boost_en;
	logic priority_arb_en, phy_accel_notify, subsys_id_load, stamp_boost;
	logic [15:0] subsystem_device_alias, subsystem_vendor_alias;
	// Reference state kept by the bench, updated as each write is issued.
	logic [31:0] m_lec, m_alias, m_base, m_evt, m_msk, d, a;
	integer seed = 85;
	integer num_errors = 0;
	integer cmp_count = 0;
	integer i;
	integer j;

	lecr_regs lecr_regs_i (.core_clk(core_clk), .srst(srst), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .evt_in(evt_in), .tx_valid(tx_valid),
		.stream_format_code(stream_format_code), .rd_data(rd_data),
		.rd_valid(rd_valid),
		.transport_stamp_boost_en(transport_stamp_boost_en),
		.video_stamp_boost_en(video_stamp_boost_en),
		.priority_arb_en(priority_arb_en),
		.phy_accel_notify(phy_accel_notify),
		.subsystem_device_alias(subsystem_device_alias),
		.subsystem_vendor_alias(subsystem_vendor_alias),
		.subsys_id_load(subsys_id_load), .stamp_boost(stamp_boost));

	// Free-running clock, 10 ns per half period.
	always #10 core_clk = ~core_clk;

	// Compares one value and counts the outcome.
	task check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			num_errors++;
		end
	endtask

	// Expected read word: the window is tested against the model's base.
	function automatic logic [31:0] exp_rd(input logic c, input logic [31:0] x);
		if (c)
			return (x[7:0] == 8'hF4) ? m_lec : (x[7:0] == 8'hF8) ? m_alias :
				(x[7:0] == 8'h10) ? m_base : 32'h0000_0000;
		if (x[31:11] != m_base[31:11])
			return 32'h0000_0000;
		case (x[10:0])
			11'h080: return m_evt;
			11'h084: return m_evt & m_msk;
			11'h088, 11'h08C: return m_msk;
			default: return 32'h0000_0000;
		endcase
	endfunction

	// One write pulse; the model follows the documented update rules.
	task wr(input logic c, input logic [31:0] x, input logic [31:0] v);
		@(negedge core_clk);
		cfg_wr = c;
		mem_wr = !c;
		cfg_addr = x[7:0];
		mem_addr = x;
		cfg_wdata = v;
		mem_wdata = v;
		if (c && x[7:0] == 8'hF4) m_lec = v & lecr_pkg::LEC_WMASK;
		if (c && x[7:0] == 8'hF8) m_alias = v;
		if (c && x[7:0] == 8'h10) m_base = v & lecr_pkg::BAR_MASK;
		if (!c && x[31:11] == m_base[31:11])
		begin
			if (x[10:0] == 11'h080) m_evt = m_evt | v;
			if (x[10:0] == 11'h084) m_evt = m_evt & ~v;
			if (x[10:0] == 11'h088) m_msk = m_msk | v;
			if (x[10:0] == 11'h08C) m_msk = m_msk & ~v;
		end
		@(negedge core_clk);
		cfg_wr = 1'b0;
		mem_wr = 1'b0;
	endtask

	// One read pulse; the answer is looked at in the cycle after the take.
	task rd(input logic c, input logic [31:0] x);
		@(negedge core_clk);
		cfg_rd = c;
		mem_rd = !c;
		cfg_addr = x[7:0];
		mem_addr = x;
		@(negedge core_clk);
		cfg_rd = 1'b0;
		mem_rd = 1'b0;
		check("rd_valid", {31'h0, rd_valid}, 32'h0000_0001);
		check("rd_data", rd_data, exp_rd(c, x));
	endtask

	// Write a configuration word, then read it in the very next cycle.
	task wr_rd(input logic [31:0] x, input logic [31:0] v);
		wr(1'b1, x, v);
		cfg_rd = 1'b1;
		@(negedge core_clk);
		cfg_rd = 1'b0;
		check("wr_rd", rd_data, exp_rd(1'b1, x));
	endtask

	// Presents one packet and checks the enhancement flag a cycle later.
	task stamp(input logic [5:0] f);
		@(negedge core_clk);
		tx_valid = 1'b1;
		stream_format_code = f;
		@(negedge core_clk);
		tx_valid = 1'b0;
		check("stamp", {31'h0, stamp_boost}, {31'h0, (f == 6'h20 && m_lec[10])
			|| (f == 6'h00 && m_lec[8])});
	endtask

	// Prints the counts and the verdict, then stops.
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence: reset, enhancement bits, alias, window and set/clear.
	initial
	begin
		{core_clk, cfg_wr, cfg_rd, mem_wr, mem_rd, tx_valid} = 6'h00;
		{cfg_addr, stream_format_code} = 14'h0000;
		{cfg_wdata, mem_addr, mem_wdata, evt_in} = 128'h0;
		{m_lec, m_alias, m_base, m_evt, m_msk} = 160'h0;
		srst = 1'b1;
		repeat (4) @(negedge core_clk);
		srst = 1'b0;
		check("enables", {28'h0, transport_stamp_boost_en, video_stamp_boost_en,
			priority_arb_en, phy_accel_notify}, 32'h0000_0000);
		rd(1'b1, 32'h0000_00F4);
		rd(1'b1, 32'h0000_00F8);
		for (i = 0; i < 6; i++)
		begin
			d = ((i == 0) ? 32'hFFFF_FFFF : $random(seed)) & 32'hFFFF_FFFB;
			wr(1'b1, 32'h0000_00F4, d);
			@(negedge core_clk);
			check("enables", {28'h0, transport_stamp_boost_en,
				video_stamp_boost_en, priority_arb_en, phy_accel_notify},
				{28'h0, m_lec[10], m_lec[8], m_lec[7], m_lec[1]});
			rd(1'b1, 32'h0000_00F4);
			stamp(6'h20);
			stamp(6'h00);
			stamp(6'($random(seed)));
			d = $random(seed);
			wr(1'b1, 32'h0000_00F8, d);
			check("id_load", {31'h0, subsys_id_load}, 32'h0000_0001);
			check("ids", {subsystem_device_alias, subsystem_vendor_alias},
				d);
			rd(1'b1, 32'h0000_00F8);
			rd(1'b1, 32'h0000_00F0);
			wr_rd(32'h0000_00F4, $random(seed) & 32'hFFFF_FFFB);
			wr_rd(32'h0000_00F8, $random(seed));
		end
		wr_rd(32'h0000_0010, $random(seed));
		rd(1'b1, 32'h0000_0010);
		for (j = 0; j < 24; j++)
		begin
			a = {m_base[31:11], 11'h080 | 11'(($random(seed) & 3) << 2)};
			wr(1'b0, a, $random(seed));
			if (j == 12)
			begin
				@(negedge core_clk);
				d = $random(seed);
				evt_in = d;
				m_evt = m_evt | d;
				@(negedge core_clk);
				evt_in = 32'h0000_0000;
			end
			rd(1'b0, {m_base[31:11], 11'h080});
			rd(1'b0, {m_base[31:11], 11'h084});
			rd(1'b0, {m_base[31:11], 11'h08C});
			rd(1'b0, {~m_base[31:11], 11'h080});
		end
		complete_run;
	end

	// Watchdog: the sequence needs well under a thousand cycles.
	initial
	begin
		#200000;
		num_errors++;
		complete_run;
	end
endmodule // testbench
